// ==== rtl/dagc_consts.svh ====
// register map, field positions and reset values of the gain loop configuration block
`ifndef DAGC_CONSTS_SVH
`define DAGC_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define DAGC_OFS_CFG_ONE      12'h000
`define DAGC_OFS_LIMITS       12'h004
`define DAGC_OFS_STROBE       12'h008
`define DAGC_OFS_HELD_GAIN    12'h00C
`define DAGC_OFS_MASTER       12'h010
`define DAGC_ADDR_W           12

// ==========================================================================
// writable bit masks, reserved bits stay zero
`define DAGC_MASK_CFG_ONE     32'h3FFF_FFFF
`define DAGC_MASK_LIMITS      32'h0FFF_0FFF
`define DAGC_MASK_MASTER      32'h0000_0FFF

// ==========================================================================
// field positions
`define DAGC_SYNC_EN_BIT      29
`define DAGC_THR_MSB          28
`define DAGC_THR_LSB          16
`define DAGC_G1_MANT_LSB      12
`define DAGC_G1_EXP_LSB       8
`define DAGC_G0_MANT_LSB      4
`define DAGC_G0_EXP_LSB       0
`define DAGC_MAX_LSB          16
`define DAGC_MIN_LSB          0

// ==========================================================================
// reset values
`define DAGC_RST_CFG_ONE      32'h0000_0000
`define DAGC_RST_LIMITS       32'h0FFF_0000
`define DAGC_RST_MASTER       32'h0000_0000

// ==========================================================================
// loop arithmetic: accumulator keeps this many bits below the 12-bit gain word
`define DAGC_ACC_FRAC         12
// shift that turns error*mantissa*2^exp into accumulator units
`define DAGC_STEP_SHIFT       11

// ==========================================================================
// bus answers
`define DAGC_RESP_OKAY        2'h0
`define DAGC_RESP_SLVERR      2'h2

`endif

// ==== rtl/dagc_pkg.sv ====
// types shared by the gain loop configuration block
package dagc_pkg;

    // ======================================================================
    // one loop gain set: unsigned fraction mant/16 and exponent
    typedef struct packed {
        logic [3:0] mant;
        logic [3:0] expo;
    } dagc_gain_set_t;

    // ======================================================================
    // 12-bit gain word: exponent over offset-binary fraction
    typedef struct packed {
        logic [3:0] expo;
        logic [7:0] frac;
    } dagc_gain_word_t;

    // ======================================================================
    // write channel of the bus slave
    typedef enum logic [2:0] {
        DAGC_W_COLLECT = 3'b001,
        DAGC_W_COMMIT  = 3'b010,
        DAGC_W_RESP    = 3'b100
    } dagc_wstate_t;

endpackage : dagc_pkg

// ==== rtl/dagc_reg_if.sv ====
// carrier between the bus slave and the register file of the gain loop block
`timescale 1ns/1ns
`default_nettype none
`include "dagc_consts.svh"

interface dagc_reg_if;
    logic                     wr_en;
    logic [`DAGC_ADDR_W-1:0]  wr_addr;
    logic [31:0]              wr_data;
    logic [3:0]               wr_strb;
    logic                     wr_ok;
    logic [`DAGC_ADDR_W-1:0]  rd_addr;
    logic [31:0]              rd_data;
    logic                     rd_ok;

    modport slave (output wr_en, output wr_addr, output wr_data, output wr_strb,
                   input wr_ok, output rd_addr, input rd_data, input rd_ok);
    modport regs  (input wr_en, input wr_addr, input wr_data, input wr_strb,
                   output wr_ok, input rd_addr, output rd_data, output rd_ok);
endinterface : dagc_reg_if

`default_nettype wire

// ==== rtl/dagc_axi_slave.sv ====
// AXI4-Lite slave front end for the gain loop registers
`timescale 1ns/1ns
`default_nettype none
`include "dagc_consts.svh"

module dagc_axi_slave (
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    reset_i,
    // write address and data
    input  wire logic [`DAGC_ADDR_W-1:0] awaddr_i,
    input  wire logic                    awvalid_i,
    output logic                         awready_o,
    input  wire logic [31:0]             wdata_i,
    input  wire logic [3:0]              wstrb_i,
    input  wire logic                    wvalid_i,
    output logic                         wready_o,
    // write response
    output logic [1:0]                   bresp_o,
    output logic                         bvalid_o,
    input  wire logic                    bready_i,
    // read
    input  wire logic [`DAGC_ADDR_W-1:0] araddr_i,
    input  wire logic                    arvalid_i,
    output logic                         arready_o,
    output logic [31:0]                  rdata_o,
    output logic [1:0]                   rresp_o,
    output logic                         rvalid_o,
    input  wire logic                    rready_i,
    // register side
    dagc_reg_if.slave                    regs
);

    // ======================================================================
    // write path: address and data are taken in either order
    dagc_pkg::dagc_wstate_t              wstate_reg;
    logic                                aw_full_reg;
    logic                                w_full_reg;
    logic [`DAGC_ADDR_W-1:0]             awaddr_reg;
    logic [31:0]                         wdata_reg;
    logic [3:0]                          wstrb_reg;

    assign awready_o     = (wstate_reg == dagc_pkg::DAGC_W_COLLECT) && !aw_full_reg;
    assign wready_o      = (wstate_reg == dagc_pkg::DAGC_W_COLLECT) && !w_full_reg;
    assign bvalid_o      = (wstate_reg == dagc_pkg::DAGC_W_RESP);
    assign regs.wr_en    = (wstate_reg == dagc_pkg::DAGC_W_COMMIT);
    assign regs.wr_addr  = awaddr_reg;
    assign regs.wr_data  = wdata_reg;
    assign regs.wr_strb  = wstrb_reg;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wstate_reg  <= dagc_pkg::DAGC_W_COLLECT;
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bresp_o     <= `DAGC_RESP_OKAY;
        end else begin
            case (wstate_reg)
                dagc_pkg::DAGC_W_COLLECT: begin
                    if (awvalid_i && awready_o) begin
                        awaddr_reg  <= awaddr_i;
                        aw_full_reg <= 1'b1;
                    end
                    if (wvalid_i && wready_o) begin
                        wdata_reg  <= wdata_i;
                        wstrb_reg  <= wstrb_i;
                        w_full_reg <= 1'b1;
                    end
                    if ((aw_full_reg || awvalid_i) && (w_full_reg || wvalid_i)) begin
                        wstate_reg <= dagc_pkg::DAGC_W_COMMIT;
                    end
                end
                dagc_pkg::DAGC_W_COMMIT: begin
                    bresp_o     <= regs.wr_ok ? `DAGC_RESP_OKAY : `DAGC_RESP_SLVERR;
                    aw_full_reg <= 1'b0;
                    w_full_reg  <= 1'b0;
                    wstate_reg  <= dagc_pkg::DAGC_W_RESP;
                end
                dagc_pkg::DAGC_W_RESP: begin
                    if (bready_i) begin
                        wstate_reg <= dagc_pkg::DAGC_W_COLLECT;
                    end
                end
                default: begin
                    wstate_reg <= dagc_pkg::DAGC_W_COLLECT;
                end
            endcase
        end
    end

    // ======================================================================
    // read path: data registered on the same edge that takes the address
    assign arready_o    = !rvalid_o;
    assign regs.rd_addr = araddr_i;

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            rvalid_o <= 1'b0;
            rdata_o  <= 32'h0000_0000;
            rresp_o  <= `DAGC_RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            rvalid_o <= 1'b1;
            rdata_o  <= regs.rd_data;
            rresp_o  <= regs.rd_ok ? `DAGC_RESP_OKAY : `DAGC_RESP_SLVERR;
        end else if (rready_i) begin
            rvalid_o <= 1'b0;
        end
    end

endmodule : dagc_axi_slave

`default_nettype wire

// ==== rtl/dagc_loop_config.sv ====
// gain loop configuration, loop filter accumulator and readback holding register
`timescale 1ns/1ns
`default_nettype none
`include "dagc_consts.svh"

// ==========================================================================
// Function
// - sync pin loads master value when enabled
// - gain error is threshold minus magnitude; code scales magnitude by 1.594 first
// - threshold signed, msb -4, lsb 2^-10
// - select high uses gain set one
// - select low uses gain set zero
// - step is 1.5dB*error*mantissa*2^-(15-exp)
// - magnitude spans zero up to 1.414
// - mantissa is unsigned value over sixteen
// - upper limit bits 27-16, exponent over fraction
// - lower limit bits 11-0, same layout
// - limit gain is 6.02*exp plus fraction term
// - strobe write captures loop output for readback
// - first config word acts on processing clock
// - limits word acts on processing clock
module dagc_loop_config (
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    reset_i,
    // AXI4-Lite write address and data
    input  wire logic [`DAGC_ADDR_W-1:0] awaddr_i,
    input  wire logic                    awvalid_i,
    output logic                         awready_o,
    input  wire logic [31:0]             wdata_i,
    input  wire logic [3:0]              wstrb_i,
    input  wire logic                    wvalid_i,
    output logic                         wready_o,
    // AXI4-Lite write response
    output logic [1:0]                   bresp_o,
    output logic                         bvalid_o,
    input  wire logic                    bready_i,
    // AXI4-Lite read
    input  wire logic [`DAGC_ADDR_W-1:0] araddr_i,
    input  wire logic                    arvalid_i,
    output logic                         arready_o,
    output logic [31:0]                  rdata_o,
    output logic [1:0]                   rresp_o,
    output logic                         rvalid_o,
    input  wire logic                    rready_i,
    // loop pins
    input  wire logic                    filter_sync_input_i,
    input  wire logic                    gain_set_select_i,
    input  wire logic [11:0]             magnitude_i,
    input  wire logic                    magnitude_valid_i,
    // applied gain and sync enable
    output logic [11:0]                  gain_o,
    output logic                         sync_enable_o
);

    // ======================================================================
    // bus front end
    dagc_reg_if regs_if ();

    dagc_axi_slave u_slave (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .awaddr_i  (awaddr_i),
        .awvalid_i (awvalid_i),
        .awready_o (awready_o),
        .wdata_i   (wdata_i),
        .wstrb_i   (wstrb_i),
        .wvalid_i  (wvalid_i),
        .wready_o  (wready_o),
        .bresp_o   (bresp_o),
        .bvalid_o  (bvalid_o),
        .bready_i  (bready_i),
        .araddr_i  (araddr_i),
        .arvalid_i (arvalid_i),
        .arready_o (arready_o),
        .rdata_o   (rdata_o),
        .rresp_o   (rresp_o),
        .rvalid_o  (rvalid_o),
        .rready_i  (rready_i),
        .regs      (regs_if.slave)
    );

    // ======================================================================
    // decode helpers
    function automatic logic is_addr(input logic [`DAGC_ADDR_W-1:0] a,
                                     input logic [`DAGC_ADDR_W-1:0] ofs);
        is_addr = (a == ofs);
    endfunction : is_addr

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb,
                                          input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = r & mask;
    endfunction : merge

    // ======================================================================
    // register file, all in the processing clock domain
    logic [31:0]  cfg_one_reg;
    logic [31:0]  limits_reg;
    logic [31:0]  master_reg;
    logic [11:0]  held_gain_reg;
    logic [`DAGC_ACC_FRAC+11:0] acc_reg;

    logic         wr_cfg_one;
    logic         wr_limits;
    logic         wr_strobe;
    logic         wr_master;

    assign wr_cfg_one = regs_if.wr_en && is_addr(regs_if.wr_addr, `DAGC_OFS_CFG_ONE);
    assign wr_limits  = regs_if.wr_en && is_addr(regs_if.wr_addr, `DAGC_OFS_LIMITS);
    assign wr_strobe  = regs_if.wr_en && is_addr(regs_if.wr_addr, `DAGC_OFS_STROBE);
    assign wr_master  = regs_if.wr_en && is_addr(regs_if.wr_addr, `DAGC_OFS_MASTER);
    // held gain is read only; writing it is answered with an error
    assign regs_if.wr_ok = is_addr(regs_if.wr_addr, `DAGC_OFS_CFG_ONE)
                        || is_addr(regs_if.wr_addr, `DAGC_OFS_LIMITS)
                        || is_addr(regs_if.wr_addr, `DAGC_OFS_STROBE)
                        || is_addr(regs_if.wr_addr, `DAGC_OFS_MASTER);

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cfg_one_reg <= `DAGC_RST_CFG_ONE;
            limits_reg  <= `DAGC_RST_LIMITS;
            master_reg  <= `DAGC_RST_MASTER;
        end else begin
            if (wr_cfg_one) begin
                cfg_one_reg <= merge(cfg_one_reg, regs_if.wr_data, regs_if.wr_strb,
                                     `DAGC_MASK_CFG_ONE);
            end
            if (wr_limits) begin
                limits_reg <= merge(limits_reg, regs_if.wr_data, regs_if.wr_strb,
                                    `DAGC_MASK_LIMITS);
            end
            if (wr_master) begin
                master_reg <= merge(master_reg, regs_if.wr_data, regs_if.wr_strb,
                                    `DAGC_MASK_MASTER);
            end
        end
    end

    // ======================================================================
    // readback; the strobe location reads as zero
    logic         rd_hit;
    assign rd_hit = is_addr(regs_if.rd_addr, `DAGC_OFS_CFG_ONE)
                 || is_addr(regs_if.rd_addr, `DAGC_OFS_LIMITS)
                 || is_addr(regs_if.rd_addr, `DAGC_OFS_STROBE)
                 || is_addr(regs_if.rd_addr, `DAGC_OFS_HELD_GAIN)
                 || is_addr(regs_if.rd_addr, `DAGC_OFS_MASTER);
    assign regs_if.rd_ok   = rd_hit;
    assign regs_if.rd_data =
        is_addr(regs_if.rd_addr, `DAGC_OFS_CFG_ONE)   ? cfg_one_reg :
        is_addr(regs_if.rd_addr, `DAGC_OFS_LIMITS)    ? limits_reg :
        is_addr(regs_if.rd_addr, `DAGC_OFS_HELD_GAIN) ? {20'h0_0000, held_gain_reg} :
        is_addr(regs_if.rd_addr, `DAGC_OFS_MASTER)    ? master_reg :
        32'h0000_0000;

    // ======================================================================
    // field extraction
    logic                      sync_en;
    logic signed [12:0]        threshold;
    dagc_pkg::dagc_gain_set_t  set_one;
    dagc_pkg::dagc_gain_set_t  set_zero;
    dagc_pkg::dagc_gain_set_t  set_sel;
    dagc_pkg::dagc_gain_word_t lim_max;
    dagc_pkg::dagc_gain_word_t lim_min;

    assign sync_en   = cfg_one_reg[`DAGC_SYNC_EN_BIT];
    // two's complement, msb weighted -2^2, lsb 2^-10
    assign threshold = cfg_one_reg[`DAGC_THR_MSB:`DAGC_THR_LSB];
    assign set_one   = cfg_one_reg[`DAGC_G1_MANT_LSB+3:`DAGC_G1_EXP_LSB];
    assign set_zero  = cfg_one_reg[`DAGC_G0_MANT_LSB+3:`DAGC_G0_EXP_LSB];
    assign set_sel   = gain_set_select_i ? set_one : set_zero;
    // gain word is exponent in dB steps of 6.02 plus log of 1.fraction
    assign lim_max   = limits_reg[`DAGC_MAX_LSB+11:`DAGC_MAX_LSB];
    assign lim_min   = limits_reg[`DAGC_MIN_LSB+11:`DAGC_MIN_LSB];

    // ======================================================================
    // gain error: threshold minus magnitude scaled by about 1.6
    // magnitude is 2^-10 per lsb, so 0 .. 1.414 fits in 11 bits of the port
    logic        [13:0]        mag_scaled;
    logic signed [14:0]        gain_err;
    logic signed [18:0]        err_x_mant;
    logic signed [34:0]        err_shifted;
    logic signed [23:0]        step;

    // 1 + 1/2 + 1/16 + 1/32 = 1.594, close to 1.6 without a multiplier
    assign mag_scaled = {2'b00, magnitude_i} + {3'b000, magnitude_i[11:1]}
                      + {6'h00, magnitude_i[11:4]} + {7'h00, magnitude_i[11:5]};
    assign gain_err   = 15'(threshold) - $signed({1'b0, mag_scaled});
    // mantissa is mant/16; the /16 and the 1.5 dB weight live in the shift
    assign err_x_mant = 19'(gain_err) * $signed({1'b0, set_sel.mant});
    assign err_shifted = 35'(err_x_mant) <<< set_sel.expo;
    // 1.5 dB is a quarter of a 6.02 dB exponent step, i.e. 64 fraction lsbs
    assign step       = 24'(err_shifted >>> `DAGC_STEP_SHIFT);

    // ======================================================================
    // accumulator update and clamp
    logic signed [25:0]        acc_sum;
    logic        [23:0]        acc_max;
    logic        [23:0]        acc_min;
    logic        [23:0]        acc_next;

    assign acc_max = {lim_max, 12'h000};
    assign acc_min = {lim_min, 12'h000};
    assign acc_sum = $signed({2'b00, acc_reg}) + 26'(step);
    // a wrap past zero or the top is caught by the sign and width checks
    assign acc_next =
        (acc_sum > $signed({2'b00, acc_max})) ? acc_max :
        (acc_sum < $signed({2'b00, acc_min})) ? acc_min :
        acc_sum[23:0];

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            acc_reg <= 24'h00_0000;
        end else if (sync_en && filter_sync_input_i) begin
            // sync wins over a sample arriving in the same cycle
            acc_reg <= {master_reg[11:0], 12'h000};
        end else if (magnitude_valid_i) begin
            acc_reg <= acc_next;
        end
    end

    // ======================================================================
    // readback holding value, frozen until the next strobe write
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            held_gain_reg <= 12'h000;
        end else if (wr_strobe) begin
            held_gain_reg <= acc_reg[23:12];
        end
    end

    // ======================================================================
    // outputs
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            gain_o        <= 12'h000;
            sync_enable_o <= 1'b0;
        end else begin
            gain_o        <= acc_reg[23:12];
            sync_enable_o <= sync_en;
        end
    end

endmodule : dagc_loop_config

`default_nettype wire

// ==== tb/dagc_loop_config_checker.sv ====
// assertion checker for the gain loop configuration block
`timescale 1ns/1ns
`default_nettype none
`include "dagc_consts.svh"

module dagc_loop_config_checker (
    // clock and reset
    input wire logic                    clock_i,
    input wire logic                    reset_i,
    // bus
    input wire logic [`DAGC_ADDR_W-1:0] awaddr_i,
    input wire logic                    awvalid_i,
    input wire logic                    awready_o,
    input wire logic                    wvalid_i,
    input wire logic                    wready_o,
    input wire logic [1:0]              bresp_o,
    input wire logic                    bvalid_o,
    input wire logic                    bready_i,
    input wire logic [`DAGC_ADDR_W-1:0] araddr_i,
    input wire logic                    arvalid_i,
    input wire logic                    arready_o,
    input wire logic [31:0]             rdata_o,
    input wire logic [1:0]              rresp_o,
    input wire logic                    rvalid_o,
    input wire logic                    rready_i,
    // loop
    input wire logic                    filter_sync_input_i,
    input wire logic                    magnitude_valid_i,
    input wire logic [11:0]             gain_o,
    input wire logic                    sync_enable_o
);
    // ==========================================================================
    // address decode, held gain is read only
    wire wmap = awaddr_i == `DAGC_OFS_CFG_ONE || awaddr_i == `DAGC_OFS_LIMITS
             || awaddr_i == `DAGC_OFS_STROBE || awaddr_i == `DAGC_OFS_MASTER;
    wire rmap = araddr_i == `DAGC_OFS_CFG_ONE || araddr_i == `DAGC_OFS_LIMITS
             || araddr_i == `DAGC_OFS_STROBE || araddr_i == `DAGC_OFS_MASTER
             || araddr_i == `DAGC_OFS_HELD_GAIN;
    wire both = awvalid_i && awready_o && wvalid_i && wready_o;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // ==========================================================================
    // assertions
    aw_busy_a: assert property (both |=> (!awready_o && !wready_o) [*2])
        else $error("address or data taken while a write is pending");
    wr_resp_a: assert property (both |-> ##2 bvalid_o && bresp_o ==
        ($past(wmap, 2) ? `DAGC_RESP_OKAY : `DAGC_RESP_SLVERR)) else $error("bad write answer");
    bresp_hold_a: assert property (
        bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("write answer dropped early");
    rd_resp_a: assert property (arvalid_i && arready_o |=> rvalid_o && rresp_o ==
        ($past(rmap) ? `DAGC_RESP_OKAY : `DAGC_RESP_SLVERR)) else $error("bad read answer");
    rdata_hold_a: assert property (
        rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
        else $error("read data dropped early");
    arready_a: assert property (arready_o != rvalid_o)
        else $error("read address ready wrong");
    gain_cause_a: assert property ($changed(gain_o) |->
        $past(magnitude_valid_i, 2) || $past(filter_sync_input_i, 2)) else $error("gain moved");
    // a held sync keeps reloading the same master value; gain shows it two edges on
    sync_hold_a: assert property (
        (sync_enable_o && filter_sync_input_i) [*2] |=> ##1 $stable(gain_o))
        else $error("repeated sync changed gain");
    c_sync: cover property (sync_enable_o && filter_sync_input_i);
    c_err: cover property (bvalid_o && bresp_o == `DAGC_RESP_SLVERR);
    c_step: cover property (magnitude_valid_i ##2 $changed(gain_o));
endmodule : dagc_loop_config_checker

bind dagc_loop_config dagc_loop_config_checker i_dagc_loop_config_checker (
    .clock_i(clock_i), .reset_i(reset_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
    .awready_o(awready_o), .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .rready_i(rready_i), .filter_sync_input_i(filter_sync_input_i),
    .magnitude_valid_i(magnitude_valid_i), .gain_o(gain_o), .sync_enable_o(sync_enable_o));

`default_nettype wire

// ==== tb/dagc_loop_config_bench.sv ====
// self-checking bench of the gain loop configuration block
`timescale 1ns/1ns
`default_nettype none
`include "dagc_consts.svh"

module dagc_loop_config_bench;
    // ==========================================================================
    // signals
    logic        clock_i = 1'h0;
    logic        reset_i = 1'h1;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        sync = 1'h0, sel = 1'h0, mvalid = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000, mag = 12'h000, gain;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic        awready, wready, bvalid, arready, rvalid, sen;
    logic [1:0]  bresp, rresp;
    int          mismatches = 0, check_count = 0, cycles = 0;

    dagc_loop_config i_dagc_loop_config (
        .clock_i(clock_i), .reset_i(reset_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
        .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'hF), .wvalid_i(wvalid),
        .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready),
        .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
        .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready), .filter_sync_input_i(sync),
        .gain_set_select_i(sel), .magnitude_i(mag), .magnitude_valid_i(mvalid),
        .gain_o(gain), .sync_enable_o(sen));
    always #5 clock_i = ~clock_i;
    // ==========================================================================
    // tasks
    task automatic test_done;
        if (mismatches == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            test_done;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // ready is raised only once the answer is seen, so a stalled answer is exercised
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tv, done = 1'h0;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!done) begin
            @(negedge clock_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tv = bvalid;
            done = bvalid && bready;
            r = bresp;
            @(posedge clock_i);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            bready <= tv && !done;
        end
        chk({30'h0, r}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tv, done = 1'h0;
        logic [31:0] d;
        logic [1:0] r;
        araddr <= a;
        arvalid <= 1'h1;
        while (!done) begin
            @(negedge clock_i);
            ta = arvalid && arready;
            tv = rvalid;
            done = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clock_i);
            if (ta) arvalid <= 1'h0;
            rready <= tv && !done;
        end
        chk(d, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask : rd

    // n cycles of samples, or of sync when y is set, then compare the applied gain
    task automatic go(input logic s, input logic [11:0] m, input logic y, input int n,
                      input logic [11:0] eg);
        sel <= s;
        mag <= m;
        mvalid <= !y;
        sync <= y;
        repeat (n) @(posedge clock_i);
        mvalid <= 1'h0;
        sync <= 1'h0;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        chk({20'h0, gain}, {20'h0, eg});
        @(posedge clock_i);
    endtask : go

    // ==========================================================================
    // tests: thr 1.0, set one 8/16 exp 10 (+1 lsb), set zero 8/16 exp 11 (+2 lsb)
    initial begin
        repeat (6) @(posedge clock_i);
        reset_i <= 1'h0;
        @(posedge clock_i);
        rd(`DAGC_OFS_LIMITS, 32'h0FFF_0000, `DAGC_RESP_OKAY);
        rd(12'h014, 32'h0000_0000, `DAGC_RESP_SLVERR);
        wr(12'h014, 32'h0000_0001, `DAGC_RESP_SLVERR);
        wr(`DAGC_OFS_HELD_GAIN, 32'h0000_0001, `DAGC_RESP_SLVERR);
        wr(`DAGC_OFS_CFG_ONE, 32'hFFFF_FFFF, `DAGC_RESP_OKAY);
        rd(`DAGC_OFS_CFG_ONE, 32'h3FFF_FFFF, `DAGC_RESP_OKAY);
        wr(`DAGC_OFS_LIMITS, 32'hFFFF_F000, `DAGC_RESP_OKAY);
        rd(`DAGC_OFS_LIMITS, 32'h0FFF_0000, `DAGC_RESP_OKAY);
        wr(`DAGC_OFS_MASTER, 32'h0000_0123, `DAGC_RESP_OKAY);
        wr(`DAGC_OFS_CFG_ONE, 32'h2400_8A8B, `DAGC_RESP_OKAY);
        go(1'h0, 12'h000, 1'h1, 2, 12'h123);
        chk({31'h0, sen}, 32'h0000_0001);
        go(1'h1, 12'h000, 1'h0, 1, 12'h124);
        go(1'h0, 12'h000, 1'h0, 1, 12'h126);
        wr(`DAGC_OFS_STROBE, 32'h0000_0000, `DAGC_RESP_OKAY);
        go(1'h0, 12'h000, 1'h0, 1, 12'h128);
        rd(`DAGC_OFS_HELD_GAIN, 32'h0000_0126, `DAGC_RESP_OKAY);
        // threshold 1632 against magnitude 1024 scaled by the 1.594 factor leaves no error
        wr(`DAGC_OFS_CFG_ONE, 32'h2660_8A8B, `DAGC_RESP_OKAY);
        go(1'h1, 12'h400, 1'h0, 1, 12'h128);
        wr(`DAGC_OFS_LIMITS, 32'h0125_0120, `DAGC_RESP_OKAY);
        go(1'h0, 12'h000, 1'h0, 1, 12'h125);
        wr(`DAGC_OFS_CFG_ONE, 32'h2000_8A8B, `DAGC_RESP_OKAY);
        go(1'h0, 12'h400, 1'h0, 2, 12'h120);
        wr(`DAGC_OFS_CFG_ONE, 32'h0000_8A8B, `DAGC_RESP_OKAY);
        go(1'h0, 12'h000, 1'h1, 2, 12'h120);
        chk({31'h0, sen}, 32'h0000_0000);
        test_done;
    end
endmodule : dagc_loop_config_bench

`default_nettype wire
